/* logic/ecpwm_pkg.sv */
package ecpwm_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DUTY = 8'h04;
  localparam logic [7:0] OFS_DEADBAND = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0c;
  localparam logic [7:0] OFS_MODE2 = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_CMP1 = 8'h18;
  localparam logic [7:0] OFS_CMP2 = 8'h1c;
  localparam logic [7:0] OFS_CAPTURE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [6:0] DEADBAND_RST = 7'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [3:0] MODE2_RST = 4'h0;
  localparam logic [15:0] CMP_RST = 16'h0000;
  // config register fields
  localparam int CFG_U1_SEC = 0;
  localparam int CFG_U2_SEC = 1;
  localparam int CFG_STEER_LSB = 4;
  // flag register fields
  localparam int FLAG_UNIT = 0;
  localparam int FLAG_SEC_OVF = 1;
  localparam int FLAG_UNIT2 = 2;
  // status register fields
  localparam int STAT_RUN = 0;
  localparam int STAT_CMP_PIN = 1;
  localparam int STAT_DIR = 2;
  // unit mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] CAP_FALL = 4'h4;
  localparam logic [3:0] CAP_RISE = 4'h5;
  localparam logic [3:0] CAP_RISE4 = 4'h6;
  localparam logic [3:0] CAP_RISE16 = 4'h7;
  localparam logic [3:0] CMP_SET = 4'h8;
  localparam logic [3:0] CMP_CLR = 4'h9;
  localparam logic [3:0] CMP_SOFT = 4'ha;
  localparam logic [3:0] CMP_SPECIAL = 4'hb;
  // output configuration codes
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_REV = 2'h3;
  // capture prescale terminal counts and dead-band counter limit
  localparam logic [3:0] CAP_DIV4 = 4'h3;
  localparam logic [3:0] CAP_DIV16 = 4'hf;
  localparam logic [6:0] DB_MAX = 7'h7f;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] output_config_field;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_field;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] own;
  } pins_t;

  typedef enum logic [1:0] {PWM_IDLE, PWM_WAIT, PWM_RUN} pwm_state_t;
endpackage

/* logic/ecpwm_mode.sv */
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// (R1) special-event match on unit using secondary timer resets that timer
// (R2) special-event match starts a conversion only if converter enabled
// (R3) software keeps timer synchronous for special-event reset to work
// (R4) timer write in same cycle as special reset wins, reset dropped
// (R5) second unit special reset never sets secondary overflow flag
// (R6) enhanced special event resets whichever 16-bit timer is selected
// (R7) non-PWM modes ignore output config; only A used, B-D port pins
// (R8) full-bridge forward: D modulated, A active, B and C inactive
// (R9) full-bridge reverse: B modulated, C active, A and D inactive
// (R10) half-bridge modulates A and B with dead band; single uses steering
// (R11) PWM duty is duty byte plus two low control bits, ten bits
// (R12) mode 0000 switches everything off and resets the unit
// (R13) mode 0010 toggles output pin on each compare match
// (R14) capture on falling, rising, every 4th or 16th rising edge
// (R15) modes 1000/1001 preset pin then set/clear on match, flag set
// (R16) mode 1010 flags match only, pin back to port control
// (R17) mode 1011 resets selected timer and sets unit flag on match
// (R18) PWM codes pick polarity: bit1 for A/C, bit0 for B/D, 1 low
// (R19) capture/compare use 16-bit timers, PWM uses period timer
// (R20) PWM output waits for start of a new period after enable
// (R21) software sets modes and port directions so pins drive out
// (R22) dead band delays activation; longer than duty keeps output inactive
// (R23) direction change: modulated off, steady switch now, resume next period
// (R24) reserved codes 0001 and 0011 leave unit fully inactive
module ecpwm_mode
  import ecpwm_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // register bus
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // 16-bit timer cores
  input wire logic [15:0] PRI_TIMER,
  input wire logic [15:0] SEC_TIMER,
  input wire logic PRI_TIMER_WR,
  input wire logic SEC_TIMER_WR,
  input wire logic SEC_TIMER_OVF,
  output logic PRI_TIMER_RST,
  output logic SEC_TIMER_RST,
  // period timer
  input wire logic PERIOD_START,
  input wire logic [9:0] PERIOD_PHASE,
  // converter
  input wire logic ADC_ON,
  output logic ADC_START,
  // pins
  input wire logic CAPTURE_PIN,
  output pins_t PINS
);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  ctrl_t ctrl;
  logic [7:0] duty_byte;
  logic [6:0] dead_band;
  logic [7:0] cfg;
  logic [3:0] mode2;
  logic [2:0] flags;
  logic [15:0] cmp1;
  logic [15:0] cmp2;
  logic [15:0] capture_val;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_do;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;

  logic [3:0] mode;
  logic [3:0] mode_d;
  logic unit_off;
  logic is_capture;
  logic is_compare;
  logic is_pwm;
  logic [15:0] t1;
  logic [15:0] t2;
  logic eq1, eq1_d, eq2, eq2_d;
  logic match1, match2;
  logic special1, special2;
  logic cmp_pin;
  logic cap_s1, cap_s2, cap_s3;
  logic rise, fall;
  logic [3:0] cap_cnt;
  logic cap_event;
  pwm_state_t pwm_state;
  logic run;
  logic [9:0] duty_q;
  logic raw;
  logic dir_q;
  logic hold_mod;
  logic [1:0] src;
  logic [6:0] db_cnt [2];
  logic [1:0] db_out;
  logic [3:0] act;
  logic [3:0] own;
  logic [3:0] pol;

  // register bus: write side holds address and data until both are in
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign wr_do = aw_held && w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_do) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    case (aw_addr)
      OFS_CTRL, OFS_DUTY, OFS_DEADBAND, OFS_CFG, OFS_MODE2, OFS_FLAGS: wr_ok = 1'b1;
      OFS_CMP1, OFS_CMP2, OFS_CAPTURE, OFS_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (wr_do) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // software registers; read-only offsets ignore writes
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= CTRL_RST;
      duty_byte <= DUTY_RST;
      dead_band <= DEADBAND_RST;
      cfg <= CFG_RST;
      mode2 <= MODE2_RST;
      cmp1 <= CMP_RST;
      cmp2 <= CMP_RST;
    end else if (wr_do) begin
      if (w_strb[0]) begin
        case (aw_addr)
          OFS_CTRL: ctrl <= w_data[7:0];
          OFS_DUTY: duty_byte <= w_data[7:0];
          OFS_DEADBAND: dead_band <= w_data[6:0];
          OFS_CFG: cfg <= w_data[7:0];
          OFS_MODE2: mode2 <= w_data[3:0];
          OFS_CMP1: cmp1[7:0] <= w_data[7:0];
          OFS_CMP2: cmp2[7:0] <= w_data[7:0];
          default: ;
        endcase
      end
      if (w_strb[1] && aw_addr == OFS_CMP1) begin
        cmp1[15:8] <= w_data[15:8];
      end
      if (w_strb[1] && aw_addr == OFS_CMP2) begin
        cmp2[15:8] <= w_data[15:8];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      OFS_CTRL: rd_mux[7:0] = ctrl;
      OFS_DUTY: rd_mux[7:0] = duty_byte;
      OFS_DEADBAND: rd_mux[6:0] = dead_band;
      OFS_CFG: rd_mux[7:0] = cfg;
      OFS_MODE2: rd_mux[3:0] = mode2;
      OFS_FLAGS: rd_mux[2:0] = flags;
      OFS_CMP1: rd_mux[15:0] = cmp1;
      OFS_CMP2: rd_mux[15:0] = cmp2;
      OFS_CAPTURE: rd_mux[15:0] = capture_val;
      OFS_STATUS: rd_mux[2:0] = {dir_q, cmp_pin, run};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // mode decode; reserved codes fall in no group
  assign mode = ctrl.unit_mode_field;
  assign unit_off = (mode == MODE_OFF); // R12
  assign is_capture = (mode[3:2] == 2'b01);
  assign is_compare = (mode == MODE_TOGGLE) || (mode[3:2] == 2'b10); // R24
  assign is_pwm = (mode[3:2] == 2'b11); // R18

  // capture/compare time bases; PWM never looks at these
  assign t1 = cfg[CFG_U1_SEC] ? SEC_TIMER : PRI_TIMER; // R19
  assign t2 = cfg[CFG_U2_SEC] ? SEC_TIMER : PRI_TIMER;
  assign eq1 = (t1 == cmp1);
  assign eq2 = (t2 == cmp2);
  // one match per arrival at the compare value, not per cycle spent there
  assign match1 = eq1 && !eq1_d && is_compare;
  assign match2 = eq2 && !eq2_d && (mode2[3:2] == 2'b10);
  assign special1 = match1 && (mode == CMP_SPECIAL); // R17
  assign special2 = match2 && (mode2 == CMP_SPECIAL); // R1

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      eq1_d <= 1'b0;
      eq2_d <= 1'b0;
      mode_d <= MODE_OFF;
    end else begin
      eq1_d <= eq1;
      eq2_d <= eq2;
      mode_d <= mode;
    end
  end

  // special-event timer resets; a coinciding core write wins
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRI_TIMER_RST <= 1'b0;
      SEC_TIMER_RST <= 1'b0;
      ADC_START <= 1'b0;
    end else begin
      PRI_TIMER_RST <= ((special1 && !cfg[CFG_U1_SEC]) || (special2 && !cfg[CFG_U2_SEC]))
                       && !PRI_TIMER_WR; // R6 R4
      SEC_TIMER_RST <= ((special1 && cfg[CFG_U1_SEC]) || (special2 && cfg[CFG_U2_SEC]))
                       && !SEC_TIMER_WR; // R1 R6 R4
      ADC_START <= (special1 || special2) && ADC_ON; // R2
    end
  end

  // compare output level
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_pin <= 1'b0;
    end else if (unit_off) begin
      cmp_pin <= 1'b0; // R12
    end else if (mode != mode_d) begin
      if (mode == CMP_SET) begin
        cmp_pin <= 1'b0; // R15
      end else if (mode == CMP_CLR) begin
        cmp_pin <= 1'b1; // R15
      end
    end else if (match1) begin
      case (mode)
        MODE_TOGGLE: cmp_pin <= !cmp_pin; // R13
        CMP_SET: cmp_pin <= 1'b1; // R15
        CMP_CLR: cmp_pin <= 1'b0; // R15
        default: ;
      endcase
    end
  end

  // capture pin synchroniser plus an edge stage
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_s3 <= 1'b0;
    end else begin
      cap_s1 <= CAPTURE_PIN;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end
  assign rise = cap_s2 && !cap_s3;
  assign fall = !cap_s2 && cap_s3;

  always_comb begin
    case (mode)
      CAP_FALL: cap_event = fall; // R14
      CAP_RISE: cap_event = rise; // R14
      CAP_RISE4: cap_event = rise && (cap_cnt == CAP_DIV4); // R14
      CAP_RISE16: cap_event = rise && (cap_cnt == CAP_DIV16); // R14
      default: cap_event = 1'b0;
    endcase
    if (mode != mode_d) begin
      cap_event = 1'b0; // R14
    end
  end

  // prescaler restarts on any mode change so the first capture is honest
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_cnt <= 4'h0;
      capture_val <= 16'h0000;
    end else if (!is_capture || mode != mode_d) begin
      cap_cnt <= 4'h0; // R12
    end else begin
      if (rise) begin
        cap_cnt <= cap_event ? 4'h0 : cap_cnt + 4'h1;
      end
      if (cap_event) begin
        capture_val <= t1; // R19
      end
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags <= 3'h0;
    end else begin
      flags[FLAG_UNIT] <= (flags[FLAG_UNIT] && !(wr_do && aw_addr == OFS_FLAGS
                          && w_strb[0] && w_data[FLAG_UNIT])) || cap_event || match1; // R15 R16 R17
      flags[FLAG_SEC_OVF] <= (flags[FLAG_SEC_OVF] && !(wr_do && aw_addr == OFS_FLAGS
                             && w_strb[0] && w_data[FLAG_SEC_OVF])) || SEC_TIMER_OVF; // R5
      flags[FLAG_UNIT2] <= (flags[FLAG_UNIT2] && !(wr_do && aw_addr == OFS_FLAGS
                           && w_strb[0] && w_data[FLAG_UNIT2])) || match2;
    end
  end

  // PWM start waits for a period boundary
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwm_state <= PWM_IDLE;
      duty_q <= 10'h000;
    end else begin
      if (PERIOD_START) begin
        duty_q <= {duty_byte, ctrl.duty_low_bits}; // R11
      end
      case (pwm_state)
        PWM_IDLE: if (is_pwm) pwm_state <= PWM_WAIT;
        PWM_WAIT: begin
          if (!is_pwm) begin
            pwm_state <= PWM_IDLE;
          end else if (PERIOD_START) begin
            pwm_state <= PWM_RUN; // R20
          end
        end
        PWM_RUN: if (!is_pwm) pwm_state <= PWM_IDLE;
        default: pwm_state <= PWM_IDLE;
      endcase
    end
  end
  assign run = (pwm_state == PWM_RUN);
  assign raw = run && (PERIOD_PHASE < duty_q); // R19

  // full-bridge direction; steady pins flip at once, modulation waits
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dir_q <= 1'b0;
      hold_mod <= 1'b0;
    end else if (is_pwm && ctrl.output_config_field[0]) begin
      if (ctrl.output_config_field[1] != dir_q) begin
        dir_q <= ctrl.output_config_field[1]; // R23
        hold_mod <= 1'b1; // R23
      end else if (PERIOD_START) begin
        hold_mod <= 1'b0; // R23
      end
    end else begin
      dir_q <= ctrl.output_config_field[1];
      hold_mod <= 1'b0;
    end
  end

  // dead band: each half-bridge output counts cycles before going active
  assign src = {run && !raw, raw};
  for (genvar i = 0; i < 2; i++) begin : g_db
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
        db_cnt[i] <= 7'h00;
      end else if (!src[i]) begin
        db_cnt[i] <= 7'h00;
      end else if (db_cnt[i] != DB_MAX) begin
        db_cnt[i] <= db_cnt[i] + 7'h01;
      end
    end
    assign db_out[i] = src[i] && (db_cnt[i] >= dead_band); // R22
  end

  // pin steering, bit order D C B A
  always_comb begin
    act = 4'h0;
    own = 4'h0;
    pol = 4'h0;
    if (is_pwm) begin
      pol = {mode[0], mode[1], mode[0], mode[1]}; // R18
      case (ctrl.output_config_field)
        CFG_SINGLE: begin
          own = cfg[CFG_STEER_LSB +: 4]; // R10
          act = {4{raw}} & own;
        end
        CFG_HALF: begin
          own = 4'h3; // R10
          act = {2'b00, db_out[1], db_out[0]}; // R10
        end
        default: begin
          own = 4'hf;
          if (!dir_q) begin
            act = {raw && !hold_mod, 1'b0, 1'b0, run}; // R8
          end else begin
            act = {1'b0, run, raw && !hold_mod, 1'b0}; // R9
          end
        end
      endcase
    end else if (is_compare && mode != CMP_SOFT) begin
      own = 4'h1; // R7
      act = {3'b000, cmp_pin};
    end else begin
      own = 4'h0; // R7 R16 R24
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PINS <= '0;
    end else begin
      PINS.level <= act ^ pol;
      PINS.own <= own;
    end
  end

  AST_SEC_RESET: assert property (special2 && cfg[CFG_U2_SEC] && !SEC_TIMER_WR
    |=> SEC_TIMER_RST) else $error("secondary timer not reset"); // R1
  AST_ADC_GATE: assert property (ADC_START |-> $past(ADC_ON) && $past(special1 || special2))
    else $error("conversion start without cause"); // R2
  AST_WRITE_WINS: assert property (SEC_TIMER_RST |-> !$past(SEC_TIMER_WR))
    else $error("reset issued over a timer write"); // R4
  AST_NO_OVF_FLAG: assert property ($rose(flags[FLAG_SEC_OVF]) |-> $past(SEC_TIMER_OVF))
    else $error("overflow flag set without overflow"); // R5
  AST_PRI_RESET: assert property (special1 && !cfg[CFG_U1_SEC] && !PRI_TIMER_WR
    |=> PRI_TIMER_RST && flags[FLAG_UNIT]) else $error("primary special event lost"); // R17
  AST_PORT_PINS: assert property (!is_pwm |=> PINS.own[3:1] == 3'b000)
    else $error("B-D claimed outside PWM"); // R7
  AST_FWD: assert property (is_pwm && ctrl.output_config_field == CFG_FWD && run
    && !dir_q && !hold_mod ##1 is_pwm |-> PINS.level[2:0] == {$past(mode[1]),
    $past(mode[0]), !$past(mode[1])}) else $error("forward steady pins wrong"); // R8
  AST_REV: assert property (is_pwm && run && dir_q && ctrl.output_config_field[0]
    |=> PINS.level[3] == $past(mode[0]) && PINS.level[0] == $past(mode[1]))
    else $error("reverse inactive pins wrong"); // R9
  AST_WAIT_PERIOD: assert property (pwm_state == PWM_WAIT && !PERIOD_START
    |=> pwm_state != PWM_RUN) else $error("PWM started mid period"); // R20
  AST_CAP4: assert property (cap_event && mode == CAP_RISE4 |=> cap_cnt == 4'h0
    && capture_val == $past(t1)) else $error("fourth-edge capture wrong"); // R14
  AST_OFF: assert property (unit_off [*2] |-> !cmp_pin && pwm_state == PWM_IDLE
    && PINS.own == 4'h0) else $error("off mode left activity"); // R12
  AST_DEAD_BAND: assert property ($rose(raw) && dead_band != 7'h00 |-> !db_out[0])
    else $error("output active inside dead band"); // R22
endmodule // ecpwm_mode

/* verif/plant_model.sv */
`timescale 1ns/100ps
module plant_model
  import ecpwm_pkg::*;
#(
  parameter int PER = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // software timer writes and unit resets
  input wire logic [1:0] wr,
  input wire logic [15:0] wr_val,
  input wire logic [1:0] tmr_rst,
  // time bases
  output logic [15:0] tmr [2],
  output logic period_start,
  output logic [9:0] phase,
  // switch drivers
  input wire pins_t pins,
  output logic [3:0] drive
);
  // timers tick on the unit clock, so a reset is lost only to a write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_n) begin
        tmr[i] <= 16'h0000;
      end else if (wr[i]) begin
        tmr[i] <= wr_val;
      end else if (tmr_rst[i]) begin
        tmr[i] <= 16'h0000;
      end else begin
        tmr[i] <= tmr[i] + 16'h0001;
      end
    end
  end

  // short period keeps the run brief
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 10'h000;
    end else begin
      phase <= (phase == 10'(PER - 1)) ? 10'h000 : phase + 10'h001;
    end
  end

  assign period_start = (phase == 10'h000);
  // released pins fall to the board pull-downs
  assign drive = pins.level & pins.own;
endmodule // plant_model

/* verif/tb_ecpwm_mode.sv */
`timescale 1ns/100ps
module tb_ecpwm_mode;
  import ecpwm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] twr = 2'b00;
  logic [15:0] wr_val = 16'h0000;
  logic ovf = 1'b0;
  logic adc_on = 1'b0;
  logic cap = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pri_rst, sec_rst, adc_start, pstart, lvl0, drv;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d;
  logic [15:0] tmr [2];
  logic [9:0] phase;
  logic [3:0] drive;
  pins_t pins;
  int num_errors = 0;
  int n_checks = 0;
  int n_prst = 0;
  int n_srst = 0;
  int n_adc = 0;
  int cnt [4];
  int s0, p0, a0;
  logic [3:0] cm [6] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'h1, 4'h3};
  int cn [4] = '{1, 1, 4, 16};

  always #25 clk = ~clk;

  // pulses are registered, so the falling edge sees them settled
  always @(negedge clk) begin
    n_prst += int'(pri_rst);
    n_srst += int'(sec_rst);
    n_adc += int'(adc_start);
  end

  ecpwm_mode u_ecpwm_mode (
    .SYS_CLK(clk),
    .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready),
    .PRI_TIMER(tmr[0]),
    .SEC_TIMER(tmr[1]),
    .PRI_TIMER_WR(twr[0]),
    .SEC_TIMER_WR(twr[1]),
    .SEC_TIMER_OVF(ovf),
    .PRI_TIMER_RST(pri_rst),
    .SEC_TIMER_RST(sec_rst),
    .PERIOD_START(pstart),
    .PERIOD_PHASE(phase),
    .ADC_ON(adc_on),
    .ADC_START(adc_start),
    .CAPTURE_PIN(cap),
    .PINS(pins)
  );

  plant_model #(.PER(64)) u_plant_model (
    .clk(clk),
    .rst_n(rst_n),
    .wr(twr),
    .wr_val(wr_val),
    .tmr_rst({sec_rst, pri_rst}),
    .tmr(tmr),
    .period_start(pstart),
    .phase(phase),
    .pins(pins),
    .drive(drive)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is sampled on the falling edge, where it already holds its edge value
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic hit, ta, tw;
    @(posedge clk);
    hit = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hit) begin
      @(negedge clk);
      hit = bvalid;
      r = bresp;
      ta = awready;
      tw = wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic hit, ta;
    @(posedge clk);
    hit = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hit) begin
      @(negedge clk);
      hit = rvalid;
      v = rdata;
      r = rresp;
      ta = arready;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_wr(a, v, resp);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, d, resp);
    check(d, e);
  endtask

  task automatic tmr_set(input logic [1:0] w, input logic [15:0] v);
    @(posedge clk);
    twr <= w;
    wr_val <= v;
    @(posedge clk);
    twr <= 2'b00;
  endtask

  task automatic pulse();
    @(posedge clk);
    cap <= 1'b1;
    repeat (5) @(posedge clk);
    cap <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic wait_start();
    do @(negedge clk); while (pstart !== 1'b1);
  endtask

  // a full period of samples counts the active cycles whatever the alignment
  task automatic count_pins();
    cnt = '{0, 0, 0, 0};
    repeat (64) begin
      @(negedge clk);
      for (int j = 0; j < 4; j++) cnt[j] += int'(drive[j]);
    end
  endtask

  function automatic int exp_cnt(input logic rev, input logic [1:0] p, input int j);
    int base;
    base = (j == (rev ? 2 : 0)) ? 64 : (j == (rev ? 1 : 3)) ? 17 : 0;
    return p[j[0] ? 0 : 1] ? 64 - base : base;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h000000a5);
    rd_chk(OFS_CTRL, 32'h000000a5);
    axi_wr(8'h40, 32'h1, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    rd_chk(8'h40, 32'h0);
    check(32'(resp), 32'(RESP_SLVERR));
    $display("test registers done");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CFG, 32'h1);
    wr(OFS_CMP1, 32'h40);
    wr(OFS_FLAGS, 32'h7);
    adc_on <= 1'b1;
    tmr_set(2'b11, 16'h0000);
    s0 = n_srst;
    p0 = n_prst;
    a0 = n_adc;
    wr(OFS_CTRL, 32'(CMP_SPECIAL));
    repeat (80) @(posedge clk);
    check(n_srst - s0, 1);
    check(n_adc - a0, 1);
    check(n_prst - p0, 0);
    rd_chk(OFS_FLAGS, 32'h1);
    adc_on <= 1'b0;
    repeat (60) @(posedge clk);
    check(n_srst - s0, 2);
    check(n_adc - a0, 1);
    while (tmr[1] !== 16'h003f) @(negedge clk);
    tmr_set(2'b10, 16'h0100);
    repeat (8) @(posedge clk);
    check(n_srst - s0, 2);
    wr(OFS_CFG, 32'h0);
    tmr_set(2'b01, 16'h0000);
    repeat (70) @(posedge clk);
    check(n_prst - p0, 1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CFG, 32'h2);
    wr(OFS_CMP2, 32'h40);
    wr(OFS_MODE2, 32'(CMP_SPECIAL));
    wr(OFS_FLAGS, 32'h7);
    tmr_set(2'b10, 16'h0000);
    repeat (70) @(posedge clk);
    check(n_srst - s0, 3);
    rd_chk(OFS_FLAGS, 32'h4);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    rd_chk(OFS_FLAGS, 32'h6);
    wr(OFS_MODE2, 32'h0);
    $display("test special event done");
    wr(OFS_CFG, 32'h0);
    foreach (cm[i]) begin
      wr(OFS_CTRL, 32'h0);
      wr(OFS_FLAGS, 32'h7);
      tmr_set(2'b01, 16'h0000);
      wr(OFS_CTRL, {24'h0, 4'hc, cm[i]});
      drv = cm[i] inside {CMP_SET, CMP_CLR, MODE_TOGGLE};
      repeat (4) @(posedge clk);
      lvl0 = pins.level[0];
      repeat (70) @(posedge clk);
      rd_chk(OFS_FLAGS, 32'(cm[i][3] | (cm[i] == MODE_TOGGLE)));
      check(32'(pins.own), 32'(drv));
      if (cm[i] inside {CMP_SET, CMP_CLR}) check(32'(lvl0), 32'(cm[i][0]));
      if (drv) check(32'(pins.level[0]), 32'(cm[i][1] ? !lvl0 : !cm[i][0]));
    end
    $display("test compare done");
    foreach (cn[i]) begin
      wr(OFS_CTRL, 32'h0);
      wr(OFS_FLAGS, 32'h7);
      wr(OFS_CTRL, 32'(CAP_FALL) + i);
      repeat (cn[i] - 1) pulse();
      rd_chk(OFS_FLAGS, 32'h0);
      pulse();
      rd_chk(OFS_FLAGS, 32'h1);
    end
    $display("test capture done");
    wr(OFS_DUTY, 32'h04);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CTRL, 32'h0);
      wait_start();
      wr(OFS_CTRL, {24'h0, k[2], 1'b1, 2'b01, 2'b11, k[1:0]});
      axi_rd(OFS_STATUS, d, resp);
      check(32'(d[STAT_RUN]), 32'h0);
      wait_start();
      wait_start();
      count_pins();
      for (int j = 0; j < 4; j++) check(cnt[j], exp_cnt(k[2], k[1:0], j));
    end
    wait_start();
    wr(OFS_CTRL, 32'h0000005f);
    repeat (3) @(posedge clk);
    check(32'(drive), 32'he);
    $display("test full bridge done");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_DEADBAND, 32'h7f);
    wr(OFS_CTRL, 32'h0000009c);
    wait_start();
    wait_start();
    count_pins();
    check(cnt[0], 0);
    check(cnt[2] + cnt[3], 0);
    wr(OFS_DEADBAND, 32'h0);
    wait_start();
    wait_start();
    count_pins();
    check(cnt[0], 17);
    check(cnt[1], 47);
    wr(OFS_CFG, 32'h50);
    wr(OFS_CTRL, 32'h1c);
    wait_start();
    count_pins();
    check(cnt[0] + cnt[2], 34);
    check(cnt[1] + cnt[3], 0);
    $display("test half bridge done");
    print_verdict();
  end
endmodule // tb_ecpwm_mode
